// File: include/seg_disp_pkg.sv
// Constants shared by the segment display driver control block
package seg_disp_pkg;
  // Register indexes on the plain register port
  localparam logic [5:0] ADDR_CONTROL = 6'h00;
  localparam logic [5:0] ADDR_PHASE = 6'h01;
  localparam logic [5:0] ADDR_SEG_EN_BASE = 6'h02;
  localparam logic [5:0] ADDR_PIX_BASE = 6'h08;
  localparam int NUM_SEG_EN = 6;
  localparam int NUM_PIX = 24;
  localparam int PIX_PER_COM = 6;
  // Control register fields
  localparam int CTL_DRV_EN_BIT = 7;
  localparam int CTL_SLP_DIS_BIT = 6;
  localparam int CTL_WRITE_ERROR_FLAG_BIT = 5;
  localparam int CTL_CS_LSB = 2;
  localparam int CTL_MUX_LSB = 0;
  // Phase register fields
  localparam int PH_WFT_BIT = 7;
  localparam int PH_BIAS_BIT = 6;
  localparam int PH_ACT_BIT = 5;
  localparam int PH_WA_BIT = 4;
  localparam int PH_LP_LSB = 0;
  // Reset values
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] PHASE_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  // Clock source codes
  localparam logic [1:0] CS_INSTR = 2'h0;
  localparam logic [1:0] CS_TIMER1 = 2'h1;
  // Instruction clock is the system clock over four
  localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
  // Postscaler ratios, stored as last count
  localparam int POST_DIV_SLOW = 8192;
  localparam int POST_DIV_FAST = 32;
  localparam logic [12:0] POST_LAST_SLOW = 13'(POST_DIV_SLOW - 1);
  localparam logic [12:0] POST_LAST_FAST = 13'(POST_DIV_FAST - 1);
  // Pixel update window after each frame boundary, in clk_sys cycles
  localparam logic [7:0] WA_WINDOW_CYCLES = 8'h40;
  // Low bit kept in partial registers of the smaller package
  localparam logic [7:0] MASK_SEG32 = 8'h01;
  localparam logic [7:0] MASK_FULL = 8'hff;
  localparam logic [7:0] MASK_NONE = 8'h00;
  // Driver run state
  typedef enum logic {ST_OFF, ST_RUN} run_state_t;
endpackage

// File: rtl/segment_display_driver_ctrl.sv
// Control, clocking and pixel storage of a multiplexed segment display driver
// What this block does
// RL1: Driver runs only while enable bit set
// RL2: Sleep stops driver only if sleep-disable set
// RL3: Pixel write while disallowed sets sticky error
// RL4: Clock field picks RC, timer1 or instruction clock
// RL5: Postscaler divides source by 32 or 8192
// RL6: Instruction clock always uses divide by 8192
// RL7: Both 31 kHz sources use divide by 32
// RL8: Frame prescale k divides by k plus one
// RL9: Commons field sets multiplexing and ring counter
// RL10: Bias bit picks half or third bias; in static and quarter mux the code ignores it and keeps half_bias low
// RL11: Waveform bit picks frame or common phase
// RL12: Read-only status shows driver active
// RL13: Read-only status shows pixel writes allowed
// RL14: Segment enable bit makes pin a driver
// RL15: Six enable registers, eight segments each
// RL16: Small package drops enables 33 to 47
// RL17: Pixel bit one means dark pixel
// RL18: Pixel registers grouped by six per common
// RL19: Small package ignores pixel registers 5,11,17,23
// RL20: Small package keeps only bit 0 of 4,10,16,22
// RL21: Up to 192 or 132 pixels
`timescale 1ns/1ps
module segment_display_driver_ctrl #(
  parameter bit PINS_64 = 1'b0
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic sleep_req,
  input wire logic internal_rc_31khz,
  input wire logic timer1_osc_input,
  output logic [47:0] segment_pin_enable,
  output logic [47:0] segment_dark,
  output logic [3:0] common_line,
  output logic drive_phase,
  output logic half_bias,
  output logic frame_tick
);

  // Mask of implemented bits in a register, by position within its group
  function automatic logic [7:0] impl_mask(input int unsigned pos);
    if (!PINS_64) begin
      impl_mask = seg_disp_pkg::MASK_FULL;
    end else if (pos == 5) begin
      impl_mask = seg_disp_pkg::MASK_NONE;
    end else if (pos == 4) begin
      impl_mask = seg_disp_pkg::MASK_SEG32;
    end else begin
      impl_mask = seg_disp_pkg::MASK_FULL;
    end
  endfunction

  // Software configuration
  logic drv_en_ff; // Driver enable
  logic sleep_drive_disable_ff; // Stop in sleep
  logic write_error_flag_ff; // Sticky write error
  logic [1:0] clk_src_ff; // Clock source select
  logic [1:0] commons_select_ff; // Last common index
  logic waveform_type_select_ff; // One for frame phase
  logic bias_mode_select_ff; // One for half bias
  logic [3:0] frame_prescale_select_ff; // Prescale ratio minus one
  logic [7:0] seg_en_ff [seg_disp_pkg::NUM_SEG_EN]; // Segment enables
  logic [7:0] pix_ff [seg_disp_pkg::NUM_PIX]; // Pixel storage

  // Run state and status
  seg_disp_pkg::run_state_t state_ff; // Driver running
  logic driver_active_status; // Status view of the run state
  logic [7:0] wa_cnt_ff; // Remaining update window
  logic write_allow_status; // Pixel writes allowed

  // Source synchronisers and edge stage
  logic rc_s1_ff, rc_s2_ff, rc_s3_ff;
  logic t1_s1_ff, t1_s2_ff, t1_s3_ff;
  logic [1:0] qdiv_ff; // Instruction clock divider
  logic src_tick; // One pulse per source period
  logic [12:0] post_ff; // Postscaler count
  logic base_tick; // About 1 kHz
  logic [3:0] pre_ff; // Prescaler count
  logic lcd_tick; // Prescaled step
  logic [1:0] com_idx_ff; // Ring counter position
  logic phase_ff; // Waveform phase
  logic com_adv; // Step to the next common
  logic frame_wrap; // Last common finished

  // Decoded accesses
  logic ctl_wr, ph_wr, pix_hit, pix_wr, pix_wr_bad;
  logic [4:0] pix_idx;

  assign driver_active_status = (state_ff == seg_disp_pkg::ST_RUN);
  assign write_allow_status = !driver_active_status || (wa_cnt_ff != 8'h00); // [RL13]
  assign pix_idx = 5'(reg_addr - seg_disp_pkg::ADDR_PIX_BASE);
  assign ctl_wr = reg_wr && (reg_addr == seg_disp_pkg::ADDR_CONTROL);
  assign ph_wr = reg_wr && (reg_addr == seg_disp_pkg::ADDR_PHASE);
  assign pix_hit = (reg_addr >= seg_disp_pkg::ADDR_PIX_BASE) // Top indexes must not alias
    && (reg_addr < 6'(seg_disp_pkg::ADDR_PIX_BASE + seg_disp_pkg::NUM_PIX));
  assign pix_wr = reg_wr && pix_hit;
  assign pix_wr_bad = pix_wr && !write_allow_status; // [RL3]

  // Control register; the error bit clears only by writing zero to it
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      drv_en_ff <= seg_disp_pkg::CONTROL_RST[seg_disp_pkg::CTL_DRV_EN_BIT];
      sleep_drive_disable_ff <= seg_disp_pkg::CONTROL_RST[seg_disp_pkg::CTL_SLP_DIS_BIT];
      clk_src_ff <= seg_disp_pkg::CONTROL_RST[seg_disp_pkg::CTL_CS_LSB +: 2];
      commons_select_ff <= seg_disp_pkg::CONTROL_RST[seg_disp_pkg::CTL_MUX_LSB +: 2];
    end else if (ctl_wr) begin
      drv_en_ff <= reg_wdata[seg_disp_pkg::CTL_DRV_EN_BIT];
      sleep_drive_disable_ff <= reg_wdata[seg_disp_pkg::CTL_SLP_DIS_BIT];
      clk_src_ff <= reg_wdata[seg_disp_pkg::CTL_CS_LSB +: 2];
      commons_select_ff <= reg_wdata[seg_disp_pkg::CTL_MUX_LSB +: 2];
    end
  end

  // Sticky error; a new bad write beats a clear in the same cycle
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      write_error_flag_ff <= seg_disp_pkg::CONTROL_RST[seg_disp_pkg::CTL_WRITE_ERROR_FLAG_BIT];
    end else if (pix_wr_bad) begin
      write_error_flag_ff <= 1'b1; // [RL3]
    end else if (ctl_wr && !reg_wdata[seg_disp_pkg::CTL_WRITE_ERROR_FLAG_BIT]) begin
      write_error_flag_ff <= 1'b0; // [RL3]
    end
  end

  // Phase register, status bits are not writable
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      waveform_type_select_ff <= seg_disp_pkg::PHASE_RST[seg_disp_pkg::PH_WFT_BIT];
      bias_mode_select_ff <= seg_disp_pkg::PHASE_RST[seg_disp_pkg::PH_BIAS_BIT];
      frame_prescale_select_ff <= seg_disp_pkg::PHASE_RST[seg_disp_pkg::PH_LP_LSB +: 4];
    end else if (ph_wr) begin
      waveform_type_select_ff <= reg_wdata[seg_disp_pkg::PH_WFT_BIT]; // [RL11]
      bias_mode_select_ff <= reg_wdata[seg_disp_pkg::PH_BIAS_BIT]; // [RL10]
      frame_prescale_select_ff <= reg_wdata[seg_disp_pkg::PH_LP_LSB +: 4]; // [RL8]
    end
  end

  // Segment enables; missing bits of the small package never store
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < seg_disp_pkg::NUM_SEG_EN; i++) begin
        seg_en_ff[i] <= seg_disp_pkg::DATA_RST;
      end
    end else begin
      for (int i = 0; i < seg_disp_pkg::NUM_SEG_EN; i++) begin
        if (reg_wr && reg_addr == 6'(seg_disp_pkg::ADDR_SEG_EN_BASE + 6'(i))) begin
          seg_en_ff[i] <= reg_wdata & impl_mask(i); // [RL15] [RL16]
        end
      end
    end
  end

  // Pixel storage, written only while the driver is stopped or inside the update window
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < seg_disp_pkg::NUM_PIX; i++) begin
        pix_ff[i] <= seg_disp_pkg::DATA_RST;
      end
    end else if (pix_wr && write_allow_status) begin
      // Partial registers keep bit 0 only, last of each group stores nothing
      pix_ff[pix_idx] <= reg_wdata & impl_mask(pix_idx % 6); // [RL19] [RL20]
    end
  end

  // Run state: enable bit, gated by sleep when sleep-disable is set
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_ff <= seg_disp_pkg::ST_OFF;
    end else if (drv_en_ff && !(sleep_req && sleep_drive_disable_ff)) begin
      state_ff <= seg_disp_pkg::ST_RUN; // [RL1] [RL2]
    end else begin
      state_ff <= seg_disp_pkg::ST_OFF; // [RL1] [RL2]
    end
  end

  // Source pins are asynchronous; third stage only feeds edge detection
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rc_s1_ff <= 1'b0;
      rc_s2_ff <= 1'b0;
      rc_s3_ff <= 1'b0;
      t1_s1_ff <= 1'b0;
      t1_s2_ff <= 1'b0;
      t1_s3_ff <= 1'b0;
    end else begin
      rc_s1_ff <= internal_rc_31khz;
      rc_s2_ff <= rc_s1_ff;
      rc_s3_ff <= rc_s2_ff;
      t1_s1_ff <= timer1_osc_input;
      t1_s2_ff <= t1_s1_ff;
      t1_s3_ff <= t1_s2_ff;
    end
  end

  // Instruction clock: free divide by four of the system clock
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      qdiv_ff <= 2'h0;
    end else begin
      qdiv_ff <= qdiv_ff + 2'h1;
    end
  end

  // Source select; the upper code bit alone picks the RC oscillator
  always_comb begin
    if (clk_src_ff[1]) begin
      src_tick = rc_s2_ff && !rc_s3_ff; // [RL4]
    end else if (clk_src_ff == seg_disp_pkg::CS_TIMER1) begin
      src_tick = t1_s2_ff && !t1_s3_ff; // [RL4]
    end else begin
      src_tick = (qdiv_ff == seg_disp_pkg::INSTR_DIV_LAST); // [RL4]
    end
  end

  // Postscaler: 8192 for the fast instruction clock, 32 for 31 kHz sources
  logic [12:0] post_last;
  assign post_last = (clk_src_ff == seg_disp_pkg::CS_INSTR) ?
    seg_disp_pkg::POST_LAST_SLOW : seg_disp_pkg::POST_LAST_FAST; // [RL5] [RL6] [RL7]
  assign base_tick = src_tick && (post_ff >= post_last);
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      post_ff <= 13'h0000;
    end else if (!driver_active_status || base_tick) begin
      post_ff <= 13'h0000; // [RL5]
    end else if (src_tick) begin
      post_ff <= post_ff + 13'h0001;
    end
  end

  // Frame prescaler: k gives a ratio of one to k plus one
  assign lcd_tick = base_tick && (pre_ff >= frame_prescale_select_ff);
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pre_ff <= 4'h0;
    end else if (!driver_active_status || lcd_tick) begin
      pre_ff <= 4'h0; // [RL8]
    end else if (base_tick) begin
      pre_ff <= pre_ff + 4'h1; // [RL8]
    end
  end

  // Type-A steps the common after both phases; Type-B every step
  assign com_adv = lcd_tick && (waveform_type_select_ff || phase_ff); // [RL11]
  assign frame_wrap = com_adv && (com_idx_ff >= commons_select_ff); // [RL9]

  // Ring counter over commons 0 to the selected last one
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      com_idx_ff <= 2'h0;
    end else if (!driver_active_status || frame_wrap) begin
      com_idx_ff <= 2'h0; // [RL9]
    end else if (com_adv) begin
      com_idx_ff <= com_idx_ff + 2'h1; // [RL9]
    end
  end

  // Phase: within each common for Type-A, at frame edges for Type-B
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      phase_ff <= 1'b0;
    end else if (!driver_active_status) begin
      phase_ff <= 1'b0;
    end else if (waveform_type_select_ff ? frame_wrap : lcd_tick) begin
      phase_ff <= !phase_ff; // [RL11]
    end
  end

  // Update window opens at each frame boundary
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wa_cnt_ff <= 8'h00;
    end else if (frame_wrap) begin
      wa_cnt_ff <= seg_disp_pkg::WA_WINDOW_CYCLES; // [RL13]
    end else if (wa_cnt_ff != 8'h00) begin
      wa_cnt_ff <= wa_cnt_ff - 8'h01;
    end
  end

  // Panel side outputs, all from flip-flops; all but the pin enables and half_bias idle when stopped
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      segment_pin_enable <= 48'h0000_0000_0000;
      segment_dark <= 48'h0000_0000_0000;
      common_line <= 4'h0;
      drive_phase <= 1'b0;
      half_bias <= 1'b0;
      frame_tick <= 1'b0;
    end else begin
      for (int i = 0; i < seg_disp_pkg::NUM_SEG_EN; i++) begin
        segment_pin_enable[i*8 +: 8] <= seg_en_ff[i]; // [RL14]
        // One means dark, only on pins given to the panel
        segment_dark[i*8 +: 8] <= driver_active_status ?
          (pix_ff[6*com_idx_ff + i] & seg_en_ff[i]) : 8'h00; // [RL17] [RL18] [RL21]
      end
      common_line <= driver_active_status ? (4'h1 << com_idx_ff) : 4'h0; // [RL1] [RL9]
      drive_phase <= phase_ff;
      // Static and quarter mux ignore the bias bit; the logic forces half_bias low
      half_bias <= bias_mode_select_ff && (commons_select_ff != 2'h0)
        && (commons_select_ff != 2'h3); // [RL10]
      frame_tick <= frame_wrap;
    end
  end

  // Read data stand for one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (!reg_rd) begin
      reg_rdata <= 8'h00;
    end else if (reg_addr == seg_disp_pkg::ADDR_CONTROL) begin
      reg_rdata <= {drv_en_ff, sleep_drive_disable_ff, write_error_flag_ff, 1'b0,
        clk_src_ff, commons_select_ff};
    end else if (reg_addr == seg_disp_pkg::ADDR_PHASE) begin
      reg_rdata <= {waveform_type_select_ff, bias_mode_select_ff, driver_active_status,
        write_allow_status, frame_prescale_select_ff}; // [RL12] [RL13]
    end else if (pix_hit) begin
      reg_rdata <= pix_ff[pix_idx];
    end else if (reg_addr < seg_disp_pkg::ADDR_PIX_BASE) begin
      reg_rdata <= seg_en_ff[3'(reg_addr - seg_disp_pkg::ADDR_SEG_EN_BASE)];
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Checks on the behaviour above
  a_error_sets: assert property (@(posedge clk_sys) disable iff (!resetn) // [RL3]
    pix_wr && !write_allow_status |=> write_error_flag_ff)
    else $error("bad pixel write did not set error");

  a_error_holds: assert property (@(posedge clk_sys) disable iff (!resetn) // [RL3]
    write_error_flag_ff && !ctl_wr |=> write_error_flag_ff)
    else $error("error flag dropped without a clear");

  a_enable_runs: assert property (@(posedge clk_sys) disable iff (!resetn) // [RL1]
    drv_en_ff && !sleep_req ##1 drv_en_ff |-> driver_active_status)
    else $error("driver not active while enabled");

  a_disable_stops: assert property (@(posedge clk_sys) disable iff (!resetn) // [RL1]
    !drv_en_ff |=> !driver_active_status ##1 common_line == 4'h0)
    else $error("commons still driven after disable");

  a_sleep_stop: assert property (@(posedge clk_sys) disable iff (!resetn) // [RL2]
    sleep_req && sleep_drive_disable_ff |=> !driver_active_status)
    else $error("driver kept running in sleep");

  a_ring_bound: assert property (@(posedge clk_sys) disable iff (!resetn) // [RL9]
    driver_active_status && $stable(commons_select_ff) |-> com_idx_ff <= commons_select_ff)
    else $error("ring counter beyond selected commons");

  a_prescale_bound: assert property (@(posedge clk_sys) disable iff (!resetn) // [RL8]
    lcd_tick |=> pre_ff == 4'h0 && post_ff == 13'h0000)
    else $error("dividers not restarted after a frame step");

  a_post_limit: assert property (@(posedge clk_sys) disable iff (!resetn) // [RL6]
    base_tick && clk_src_ff == seg_disp_pkg::CS_INSTR |-> post_ff == 13'h1fff)
    else $error("instruction clock not divided by 8192");

  a_small_enables: assert property (@(posedge clk_sys) disable iff (!resetn) // [RL16]
    PINS_64 |-> segment_pin_enable[47:33] == 15'h0000)
    else $error("absent segment enables driven");

  a_small_ignored: assert property (@(posedge clk_sys) disable iff (!resetn) // [RL19]
    PINS_64 |-> pix_ff[5] == 8'h00 && pix_ff[23] == 8'h00)
    else $error("absent pixel register stored data");

endmodule

// File: bench/display_panel_model.sv
// Passive multiplexed segment panel that records the pixels it is driven with
`timescale 1ns/1ps
module display_panel_model (
  input wire logic clk_sys,
  input wire logic wipe,
  input wire logic [47:0] segment_dark,
  input wire logic [3:0] common_line,
  output logic [3:0][47:0] image,
  output logic [3:0] coms_seen,
  output logic bad_common
);
  // Row of the selected common is stored; a glass cell only sees its own common
  always @(posedge clk_sys) begin
    if (wipe) begin
      image <= '0;
      coms_seen <= 4'h0;
      bad_common <= 1'b0;
    end else begin
      for (int c = 0; c < 4; c++) begin
        // Dark cells of this common row
        if (common_line[c] === 1'b1) begin
          image[c] <= segment_dark;
        end
      end
      coms_seen <= coms_seen | common_line;
      // Two commons at once would smear rows together
      if ($countones(common_line) > 1) begin
        bad_common <= 1'b1;
      end
    end
  end
endmodule

// File: bench/tb.sv
// Self-checking bench for the segment display driver control block
`timescale 1ns/1ps
module tb;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [5:0] reg_addr = 6'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic sleep_req = 1'b0;
  logic rc_pin = 1'b0;
  logic t1_pin = 1'b0;
  logic wipe = 1'b1;
  logic [7:0] reg_rdata, rdata64, rd_v, rd_v64;
  logic [47:0] segment_pin_enable, seg_en64, segment_dark, en48;
  logic [3:0] common_line, coms_seen;
  logic drive_phase, half_bias, frame_tick, bad_common;
  logic [3:0][47:0] image;
  logic [7:0] pix [24];
  logic [7:0] sen [6];
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int div = 0;

  always #20 clk_sys = ~clk_sys;

  // Source pins locked to clk_sys so that frame periods are exact: RC 4, timer1 6
  always @(posedge clk_sys) begin
    div <= div + 1;
    rc_pin <= (div % 4) < 2;
    t1_pin <= (div % 6) < 3;
  end

  segment_display_driver_ctrl #(.PINS_64(1'b0)) segment_display_driver_ctrl_i (
    .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_req(sleep_req),
    .internal_rc_31khz(rc_pin), .timer1_osc_input(t1_pin),
    .segment_pin_enable(segment_pin_enable), .segment_dark(segment_dark),
    .common_line(common_line), .drive_phase(drive_phase), .half_bias(half_bias),
    .frame_tick(frame_tick));
  // Smaller package shares the register traffic; only its map is judged
  segment_display_driver_ctrl #(.PINS_64(1'b1)) segment_display_driver_ctrl_64_i (
    .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata64), .sleep_req(sleep_req),
    .internal_rc_31khz(rc_pin), .timer1_osc_input(t1_pin),
    .segment_pin_enable(seg_en64), .segment_dark(), .common_line(), .drive_phase(),
    .half_bias(), .frame_tick());
  display_panel_model display_panel_model_i (
    .clk_sys(clk_sys), .wipe(wipe), .segment_dark(segment_dark),
    .common_line(common_line), .image(image), .coms_seen(coms_seen),
    .bad_common(bad_common));

  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Hang guard, well above the longest expected run
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_count++;
      report_and_stop();
    end
  end

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_vec(input logic [47:0] got, input logic [47:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Each task waits an edge first, so strobes never rise where they fell
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the read edge
  task automatic rd(input logic [5:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    rd_v = reg_rdata;
    rd_v64 = rdata64;
  endtask

  task automatic wait_tick(output time t, output logic ph, input int lim);
    for (int i = 0; i < lim; i++) begin
      @(negedge clk_sys);
      if (frame_tick === 1'b1) break;
    end
    t = $time;
    ph = drive_phase;
  endtask

  // Polls the write window status until it reads v
  task automatic wait_wa(input logic v);
    for (int i = 0; i < 1500; i++) begin
      rd(6'h01);
      if (rd_v[4] === v) break;
    end
  endtask

  // Clock cycles per frame: source period, postscale 32, prescale, commons, phases
  function automatic logic [47:0] frame_cycles(input logic [1:0] cs, input logic [1:0] mux,
                                               input logic [3:0] lp, input logic waveform_type_select);
    frame_cycles = 48'((cs[1] ? 4 : 6) * 32 * (lp + 1) * (mux + 1) * (waveform_type_select ? 1 : 2));
  endfunction

  function automatic logic [47:0] row_exp(input int c);
    for (int i = 0; i < 6; i++) row_exp[8 * i +: 8] = pix[6 * c + i] & sen[i];
  endfunction

  // Smaller package: enable 5 and pixel index 5 absent, index 4 keeps bit 0
  function automatic logic [7:0] small_pkg(input int i);
    logic [7:0] v;
    int k;
    v = (i < 6) ? sen[i] : pix[i - 6];
    k = (i < 6) ? i : (i - 6) % 6;
    small_pkg = (k == 5) ? 8'h00 : (k == 4) ? (v & 8'h01) : v;
  endfunction

  initial begin
    time t0, t1;
    logic p0, p1, waveform_type_select, bias;
    logic [1:0] cs, mux;
    logic [3:0] lp;
    logic [7:0] ctl;
    void'($urandom(32'h4541));
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    // Reset image, plus the unmapped index 0x20
    for (int a = 0; a < 33; a++) begin
      rd(6'(a));
      chk_reg(rd_v, (a == 1) ? 8'h10 : 8'h00);
    end
    for (int i = 0; i < 6; i++) begin
      sen[i] = (i == 4) ? 8'hff : 8'($urandom);
      wr(6'(2 + i), sen[i]);
      en48[8 * i +: 8] = sen[i];
    end
    // Row 0 fully dark as a corner case, the rest random
    for (int i = 0; i < 24; i++) begin
      pix[i] = (i < 6) ? 8'hff : 8'($urandom);
      wr(6'(8 + i), pix[i]);
    end
    wr(6'h20, 8'h5a);
    for (int i = 0; i < 30; i++) begin
      rd(6'(2 + i));
      chk_reg(rd_v, (i < 6) ? sen[i] : pix[i - 6]);
      chk_reg(rd_v64, small_pkg(i));
    end
    chk_vec(segment_pin_enable, en48);
    chk_vec(seg_en64, {15'h0000, en48[32:0]});
    // Status bits and the unused bit ignore writes; error bit written 1 stays clear
    wr(6'h00, 8'h3f);
    rd(6'h00);
    chk_reg(rd_v, 8'h0f);
    wr(6'h01, 8'hbf);
    rd(6'h01);
    chk_reg(rd_v, 8'h9f);
    // Frame timing across source codes 1 to 3 and every commons mode
    for (int n = 0; n < 6; n++) begin
      cs = 2'((n % 3) + 1);
      mux = (n < 4) ? 2'(n) : 2'($urandom);
      waveform_type_select = 1'(n % 2);
      lp = 4'($urandom % 2);
      bias = 1'($urandom) && (mux == 2'h1 || mux == 2'h2);
      ctl = {1'b1, 3'b000, cs, mux};
      wr(6'h00, 8'h00);
      wr(6'h01, {waveform_type_select, bias, 2'b00, lp});
      wipe <= 1'b1;
      wr(6'h00, ctl);
      wait_tick(t0, p0, 20000);
      wipe <= 1'b0;
      wait_tick(t1, p1, 20000);
      chk_vec(48'((t1 - t0) / 40), frame_cycles(cs, mux, lp, waveform_type_select));
      chk_vec(48'(coms_seen), 48'((1 << (mux + 1)) - 1));
      chk_vec(48'(p0 ^ p1), 48'(waveform_type_select));
      chk_vec(48'(half_bias), 48'(bias && (mux == 2'h1 || mux == 2'h2)));
      for (int c = 0; c < 4; c++) begin
        chk_vec(image[c], (c <= mux) ? row_exp(c) : 48'h0);
      end
    end
    chk_vec(48'(bad_common), 48'h0);
    // Write window: accepted inside it, refused and flagged outside
    wait_wa(1'b1);
    pix[0] = 8'h3c;
    wr(6'h08, pix[0]);
    rd(6'h08);
    chk_reg(rd_v, pix[0]);
    repeat (70) @(posedge clk_sys);
    rd(6'h01);
    chk_reg(rd_v & 8'h30, 8'h20);
    wr(6'h08, ~pix[0]);
    rd(6'h08);
    chk_reg(rd_v, pix[0]);
    wr(6'h00, ctl | 8'h20);
    rd(6'h00);
    chk_reg(rd_v, ctl | 8'h20);
    wr(6'h00, ctl);
    rd(6'h00);
    chk_reg(rd_v, ctl);
    // Sleep keeps the display unless the sleep-disable bit is set
    @(posedge clk_sys);
    sleep_req <= 1'b1;
    rd(6'h01);
    chk_reg(rd_v & 8'h20, 8'h20);
    wr(6'h00, ctl | 8'h40);
    rd(6'h01);
    chk_reg(rd_v & 8'h20, 8'h00);
    chk_vec(48'(common_line), 48'h0);
    @(posedge clk_sys);
    sleep_req <= 1'b0;
    wr(6'h00, 8'h00);
    rd(6'h01);
    chk_reg(rd_v & 8'h30, 8'h10);
    chk_vec(48'(common_line), 48'h0);
    // Instruction clock: static, one step per frame, 4 x 8192 clocks
    wr(6'h01, 8'h80);
    wr(6'h00, 8'h80);
    t0 = $time;
    wait_tick(t1, p1, 40000);
    chk_vec(48'(((t1 - t0) / 40) inside {[32760 : 32780]}), 48'h1);
    report_and_stop();
  end
endmodule
